//--- dv/pcs_host.sv
// host model driving the three-wire serial port
`timescale 1ns/1ps
module pcs_host (
   input wire logic core_clk,
   output logic ser_clk,
   output logic ser_data,
   output logic ser_load
);
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_load = 1'b0;
   end
   task automatic send(input logic [23:0] w);
      for (int i = 23; i >= 0; i--) begin
         @(posedge core_clk) ser_data <= w[i];
         repeat (2) @(posedge core_clk);
         ser_clk <= 1'b1;
         repeat (3) @(posedge core_clk);
         ser_clk <= 1'b0;
      end
      repeat (2) @(posedge core_clk);
      ser_load <= 1'b1;
      repeat (2) @(posedge core_clk);
      ser_load <= 1'b0;
      // released line shows inverse of last bit
      ser_data <= ~w[0];
   endtask : send
endmodule : pcs_host

//--- dv/pcs_regs_tb.sv
// self-checking bench of the serial register bank
`timescale 1ns/1ps
module pcs_regs_tb;
   import pcs_pkg::*;
   logic core_clk, rst_b, ser_clk, ser_data, ser_load, lock_detect, temp_level, reg_wr, reg_rd;
   logic irq, low_pwr, osc, mon, cal_busy;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   pcs_word_t cfg_int, cfg_mod, cfg_frac;
   pcs_word_t setup_w [5] = '{24'hf0f0f7, 24'h200006, 24'h000025, 24'h0000cc, 24'h00a5a3};
   pcs_word_t tune_w [3] = '{24'h345672, 24'h000301, 24'h000380};
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   pcs_regs #(.CAL_CYC(4)) dut (.core_clk(core_clk), .rst_b(rst_b), .ser_clk(ser_clk), .ser_data(ser_data),
      .ser_load(ser_load), .lock_detect(lock_detect), .temp_level(temp_level), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .low_power_bias_enable(low_pwr), .oscillator_supply_regulator(osc), .monitor_output_pin(mon),
      .cal_busy(cal_busy), .cfg_int(cfg_int), .cfg_mod(cfg_mod), .cfg_frac(cfg_frac));
   pcs_host host (.core_clk(core_clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string what);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(what, {16'h0, reg_rdata}, {16'h0, e});
   endtask : rd
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         wrap_up();
      end
   end
   initial begin
      rst_b = 1'b0;
      lock_detect = 1'b1;
      temp_level = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      #1 chk("regulator", osc, 24'h1);
      chk("low_power", low_pwr, 24'h0);
      repeat (2) @(posedge core_clk);
      #1 chk("monitor", mon, 24'h1);
      // descending setup of registers 7 down to 3, frequency registers left for retuning
      for (int k = 0; k < 5; k++) begin
         host.send(setup_w[k]);
         #1 chk("busy", cal_busy, 24'h0);
         rd({1'b0, setup_w[k][2:0]}, setup_w[k][7:0], "reg");
      end
      chk("regulator", osc, 24'h0);
      chk("low_power", low_pwr, 24'h1);
      rd(4'ha, 8'h02, "ctrl");
      rd(4'hd, 8'h25, "unmapped");
      @(posedge core_clk);
      temp_level <= 1'b1;
      lock_detect <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 chk("monitor", mon, 24'h1);
      @(posedge core_clk);
      temp_level <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 chk("monitor", mon, 24'h0);
      wr(4'h9, 8'h01);
      for (int k = 0; k < 3; k++) begin
         host.send(tune_w[k]);
         #1 chk("busy", cal_busy, 24'h1);
      end
      repeat (2) @(posedge core_clk);
      #1 chk("cfg_int", cfg_int, tune_w[2]);
      chk("cfg_mod", cfg_mod, tune_w[1]);
      chk("cfg_frac", cfg_frac, tune_w[0]);
      chk("irq", irq, 24'h1);
      repeat (10) @(posedge core_clk);
      #1 chk("busy", cal_busy, 24'h0);
      rd(4'h8, 8'h03, "status");
      wr(4'h8, 8'h03);
      repeat (2) @(posedge core_clk);
      #1 chk("irq", irq, 24'h0);
      host.send(tune_w[2]);
      #1 chk("busy", cal_busy, 24'h1);
      repeat (2) @(posedge core_clk);
      #1 chk("irq", irq, 24'h1);
      wrap_up();
   end
endmodule : pcs_regs_tb

//--- src/pcs_defs.svh
// offsets, field positions and timing counts of the serial register bank
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH
`define PCS_WORD_W 24
`define PCS_ADDR_W 3
`define PCS_NUM_REGS 8
`define PCS_R_INT 3'h0
`define PCS_R_MOD 3'h1
`define PCS_R_FRAC 3'h2
`define PCS_R_BIAS 3'h5
`define PCS_R_LDO 3'h6
`define PCS_LOWPWR_BIT 5
`define PCS_LDO_BIT 18
`define PCS_MON_BIT 21
`define PCS_CAL_TIME_US 10
`define PCS_CLK_MHZ 100
`define PCS_CAL_CYC (`PCS_CAL_TIME_US * `PCS_CLK_MHZ)
`define PCS_ADR_STAT 4'h8
`define PCS_ADR_MASK 4'h9
`define PCS_ADR_CTRL 4'ha
`define PCS_INT_CAL_START 0
`define PCS_INT_CAL_DONE 1
`endif

//--- src/pcs_pkg.sv
// types of the serial register bank
package pcs_pkg;
   typedef enum logic [2:0] {
      PCS_IDLE = 3'b001,
      PCS_CAL = 3'b010,
      PCS_DONE = 3'b100
   } pcs_cal_state_t;
   typedef logic [23:0] pcs_word_t;
endpackage : pcs_pkg

//--- src/pcs_regs.sv
// serial configuration register bank with calibration start and monitor selection
//
// Behaviour
// - eight configuration registers, all written over a three-wire serial port
// - any write to register 0, 1 or 2 starts synthesizer calibration
// - later retuning rewrites only registers 0-2, each retriggering calibration
// - register 5 bit 5 set selects low-power bias
// - register 6 bit 18 cleared powers down the oscillator regulator
// - monitor pin shows lock-detect or temperature level, chosen by register
// - low three word bits select target register; 000 is register 0
`timescale 1ns/1ps
`include "pcs_defs.svh"
module pcs_regs #(
   parameter int CAL_CYC = `PCS_CAL_CYC
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_load,
   input wire logic lock_detect,
   input wire logic temp_level,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq,
   output logic low_power_bias_enable,
   output logic oscillator_supply_regulator,
   output logic monitor_output_pin,
   output logic cal_busy,
   output pcs_pkg::pcs_word_t cfg_int,
   output pcs_pkg::pcs_word_t cfg_mod,
   output pcs_pkg::pcs_word_t cfg_frac
);
   import pcs_pkg::*;

   pcs_word_t shift_r;
   pcs_word_t regs_r [`PCS_NUM_REGS];
   logic sclk_d_r;
   logic load_d_r;
   logic commit;
   logic [`PCS_ADDR_W-1:0] tgt;
   logic cal_kick;
   pcs_cal_state_t st_r;
   logic [15:0] cnt_r;
   logic [1:0] stat_r;
   logic [1:0] mask_r;
   logic [1:0] ev;
   logic done_ev;

   function automatic logic is_freq_reg(input logic [`PCS_ADDR_W-1:0] a);
      return (a == `PCS_R_INT) || (a == `PCS_R_MOD) || (a == `PCS_R_FRAC);
   endfunction : is_freq_reg

   // serial clock sampled in the core domain, rising edge shifts
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sclk_d_r <= 1'b0;
         load_d_r <= 1'b0;
      end else begin
         sclk_d_r <= ser_clk;
         load_d_r <= ser_load;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         shift_r <= 24'h000000;
      end else if (ser_clk && !sclk_d_r) begin
         shift_r <= {shift_r[`PCS_WORD_W-2:0], ser_data};
      end
   end

   assign commit = ser_load && !load_d_r;
   assign tgt = shift_r[`PCS_ADDR_W-1:0];

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < `PCS_NUM_REGS; i++) begin
            regs_r[i] <= 24'h000000;
         end
         regs_r[`PCS_R_LDO] <= 24'h040000;
      end else if (commit) begin
         regs_r[tgt] <= shift_r;
      end
   end

   assign cal_kick = commit && is_freq_reg(tgt);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= PCS_IDLE;
         cnt_r <= 16'h0000;
      end else if (cal_kick) begin
         st_r <= PCS_CAL;
         cnt_r <= 16'(CAL_CYC - 1);
      end else begin
         unique case (st_r)
            PCS_IDLE: begin
               cnt_r <= 16'h0000;
            end
            PCS_CAL: begin
               if (cnt_r == 16'h0000) begin
                  st_r <= PCS_DONE;
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
            PCS_DONE: begin
               st_r <= PCS_IDLE;
            end
         endcase
      end
   end

   assign done_ev = (st_r == PCS_DONE);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         low_power_bias_enable <= 1'b0;
         oscillator_supply_regulator <= 1'b1;
         monitor_output_pin <= 1'b0;
         cal_busy <= 1'b0;
         cfg_int <= 24'h000000;
         cfg_mod <= 24'h000000;
         cfg_frac <= 24'h000000;
      end else begin
         low_power_bias_enable <= regs_r[`PCS_R_BIAS][`PCS_LOWPWR_BIT];
         oscillator_supply_regulator <= regs_r[`PCS_R_LDO][`PCS_LDO_BIT];
         monitor_output_pin <= regs_r[`PCS_R_LDO][`PCS_MON_BIT] ? temp_level : lock_detect;
         cal_busy <= (st_r == PCS_CAL) || cal_kick;
         cfg_int <= regs_r[`PCS_R_INT];
         cfg_mod <= regs_r[`PCS_R_MOD];
         cfg_frac <= regs_r[`PCS_R_FRAC];
      end
   end

   // sticky status, set wins over write-one-clear
   assign ev = {done_ev, cal_kick};
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         stat_r <= 2'h0;
      end else if (reg_wr && reg_addr == `PCS_ADR_STAT) begin
         stat_r <= (stat_r & ~reg_wdata[1:0]) | ev;
      end else begin
         stat_r <= stat_r | ev;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_r <= 2'h0;
      end else if (reg_wr && reg_addr == `PCS_ADR_MASK) begin
         mask_r <= reg_wdata[1:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_r & mask_r);
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `PCS_ADR_STAT: reg_rdata <= {6'h00, stat_r};
            `PCS_ADR_MASK: reg_rdata <= {6'h00, mask_r};
            `PCS_ADR_CTRL: reg_rdata <= {5'h00, oscillator_supply_regulator, low_power_bias_enable, cal_busy};
            default: reg_rdata <= regs_r[reg_addr[2:0]][7:0];
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   AST_CAL_START: assert property (@(posedge core_clk) disable iff (!rst_b)
      cal_kick |=> (st_r == PCS_CAL) && cal_busy)
      else $error("calibration not started");
   AST_CAL_END: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_r == PCS_CAL && cnt_r == 16'h0000 && !cal_kick) |=> done_ev)
      else $error("calibration did not finish");
   AST_ROUTE: assert property (@(posedge core_clk) disable iff (!rst_b)
      commit |=> regs_r[$past(tgt)] == $past(shift_r))
      else $error("word not routed");
   AST_SHIFT: assert property (@(posedge core_clk) disable iff (!rst_b)
      (ser_clk && !sclk_d_r) |=> shift_r[0] == $past(ser_data))
      else $error("shift wrong");
   AST_LOWPWR: assert property (@(posedge core_clk) disable iff (!rst_b)
      (commit && tgt == `PCS_R_BIAS) |-> ##2 low_power_bias_enable == $past(shift_r[`PCS_LOWPWR_BIT], 2))
      else $error("low power not applied");
   AST_LDO: assert property (@(posedge core_clk) disable iff (!rst_b)
      (commit && tgt == `PCS_R_LDO) |-> ##2 oscillator_supply_regulator == $past(shift_r[`PCS_LDO_BIT], 2))
      else $error("regulator not applied");
   AST_MON: assert property (@(posedge core_clk) disable iff (!rst_b)
      rst_b && $stable(regs_r[`PCS_R_LDO]) |=> monitor_output_pin == ($past(regs_r[`PCS_R_LDO][`PCS_MON_BIT]) ?
      $past(temp_level) : $past(lock_detect)))
      else $error("monitor mux wrong");
   AST_NO_CAL: assert property (@(posedge core_clk) disable iff (!rst_b)
      (commit && !is_freq_reg(tgt) && st_r == PCS_IDLE) |=> st_r == PCS_IDLE)
      else $error("spurious calibration");
endmodule : pcs_regs
